// ---- design/gpio_defs.svh ----
// register offsets, field positions, reset values for the port 2/3 block
// assumes inclusion by bare name from design files only
`ifndef GPIO_DEFS_SVH
`define GPIO_DEFS_SVH

`define P2_DATA_ADDR 16'hFFD5
`define P3_DATA_ADDR 16'hFFD6
`define P2_DIR_ADDR 16'hFFE5
`define P3_DIR_ADDR 16'hFFE6
`define P3_PULLUP_ADDR 16'hFFEE
`define P3_PIN_MODE_ADDR 16'hFFFD
`define AUX_PIN_MODE_ADDR 16'hFFFF

`define DATA_RESET 8'h00
`define DIR_RESET 8'h00
`define WO_READ_VALUE 8'hFF
`define AUX_RESET 8'hF8
`define AUX_RSVD_ONES 8'hF8
`define UNMAPPED_READ 8'h00

`define AUX_TXD_BIT 2
`define AUX_POF_BIT 0
`define P3_MODE_BITS 3

`define P2_SCK_BIT 0
`define P2_RXD_BIT 1
`define P2_TXD_BIT 2
`define P3_OD_BIT 2

`endif

// ---- design/gpio_pkg.sv ----
// types shared by the port 2/3 block and its testbench
// assumes gpio_defs.svh for numeric constants
package gpio_pkg;

  // gray coded along active -> subactive -> sleep -> subsleep -> watch
  typedef enum logic [2:0] {
    PM_ACTIVE    = 3'h0,
    PM_SUBACTIVE = 3'h1,
    PM_SLEEP     = 3'h3,
    PM_SUBSLEEP  = 3'h2,
    PM_WATCH     = 3'h6,
    PM_STANDBY   = 3'h7
  } power_mode_t;

endpackage

// ---- design/gpio_pin_drv.sv ----
// one registered pin driver: functional, held, or released
// assumes the caller decodes the power mode into hiz_en and func_en
`timescale 1ns/1ps
module gpio_pin_drv (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // mode
  input wire logic func_en,
  input wire logic hiz_en,
  // wanted drive
  input wire logic drive_val,
  input wire logic drive_en,
  input wire logic open_drain,
  // pad
  output logic pin_out,
  output logic pin_oe
);
  logic out_nxt;
  logic oe_nxt;

  always_comb begin
    out_nxt = pin_out;
    oe_nxt = pin_oe;
    if (hiz_en) begin
      oe_nxt = 1'b0;
    end else if (func_en) begin
      out_nxt = drive_val;
      // open drain only pulls low
      oe_nxt = drive_en && !(open_drain && drive_val);
    end
  end

  // neither hiz nor func: sleep-like modes keep the last drive
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
    end else begin
      pin_out <= out_nxt;
      pin_oe <= oe_nxt;
    end
  end
endmodule

// ---- design/port2_port3_gpio.sv ----
// port 2 (8 pins) and port 3 data side (6 pins) general purpose i/o
// assumes a one-cycle register port and serial unit controls as inputs
//
// Summary of operation
// [R1] port 2 has eight pins, each usable as input or output
// [R2] direction bit 1 drives pin from data latch; 0 makes it input
// [R3] port 2 data read returns latch for output-direction bits
// [R4] port 2 data read returns live pin level for input-direction bits
// [R5] port 2 direction register is write-only and reads all ones
// [R6] direction and data act only while serial controls leave pin as gpio
// [R7] reset clears port 2 data and direction, all pins start as inputs
// [R8] pin 1 is serial receive input while receive enable is set
// [R9] pin 0: clock input, clock output, or gpio per clock selects and serial sync mode
// [R10] pins hi-z in reset/standby, hold in sleeps/watch, work when active
// [R11] port 3 has six gpio pins on data bits 5 down to 0
// [R12] port 3 data read: latch for outputs, pin level for inputs
// [R13] port 3 upper data bits read zero, ignore writes; reset clears
// [R14] auxiliary pin mode register resets to upper five ones, low three zero
// [R15] pin 2 is serial transmit output while aux mode bit 2 is set
// [R16] data writes always update the latch, even for input bits
`timescale 1ns/1ps
`include "gpio_defs.svh"
module port2_port3_gpio #(
  parameter int P2_PINS = 8,
  parameter int P3_PINS = 6
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register port
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // operating mode
  input wire gpio_pkg::power_mode_t power_mode,
  // serial unit controls and data
  input wire logic serial_rx_enable,
  input wire logic clock_select_high,
  input wire logic clock_select_low,
  input wire logic serial_sync_mode,
  input wire logic serial_tx_data,
  input wire logic serial_clock_out,
  output logic serial_rx_data,
  output logic serial_clock_in,
  // port 2 pins
  input wire logic [P2_PINS-1:0] p2_pin_in,
  output logic [P2_PINS-1:0] p2_pin_out,
  output logic [P2_PINS-1:0] p2_pin_oe,
  // port 3 pins
  input wire logic [P3_PINS-1:0] p3_pin_in,
  output logic [P3_PINS-1:0] p3_pin_out,
  output logic [P3_PINS-1:0] p3_pin_oe,
  output logic [P3_PINS-1:0] p3_pullup_en,
  output logic [`P3_MODE_BITS-1:0] port3_pin_mode_sel
);
  import gpio_pkg::*;

  localparam int NP = P2_PINS + P3_PINS;
  // a literal cannot be bit-selected, so hold the reset image here
  localparam logic [7:0] AUX_INIT = `AUX_RESET;

  // register state
  logic [P2_PINS-1:0] port2_data_latch_r, port2_data_latch_nxt;
  logic [P2_PINS-1:0] port2_direction_ctrl_r, port2_direction_ctrl_nxt;
  logic [P3_PINS-1:0] port3_data_latch_r, port3_data_latch_nxt;
  logic [P3_PINS-1:0] port3_direction_ctrl_r, port3_direction_ctrl_nxt;
  logic [P3_PINS-1:0] port3_pullup_ctrl_r, port3_pullup_ctrl_nxt;
  logic [`P3_MODE_BITS-1:0] pin_mode_r, pin_mode_nxt;
  logic aux_txd_r, aux_txd_nxt;
  logic aux_pof_r, aux_pof_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic rx_data_r, rx_data_nxt;
  logic clk_in_r, clk_in_nxt;
  logic [P3_PINS-1:0] pullup_r, pullup_nxt;

  // read views
  logic [7:0] p2_read_val;
  logic [7:0] p3_read_val;
  logic [7:0] aux_read_val;

  // pin drive wishes
  logic [P2_PINS-1:0] p2_want_out, p2_want_oe;
  logic [NP-1:0] want_out, want_oe, want_od;
  logic [NP-1:0] pin_out_all, pin_oe_all;
  logic func_en, hiz_en;

  // mode decode
  always_comb begin
    func_en = 1'b0;
    hiz_en = 1'b0;
    case (power_mode)
      PM_ACTIVE, PM_SUBACTIVE: func_en = 1'b1; // [R10]
      PM_STANDBY: hiz_en = 1'b1; // [R10]
      PM_SLEEP, PM_SUBSLEEP, PM_WATCH: func_en = 1'b0;
      // an undefined mode releases the pads rather than guess
      default: hiz_en = 1'b1;
    endcase
  end

  // read values built from latch or pad per direction bit
  always_comb begin
    p2_read_val = 8'((port2_data_latch_r & port2_direction_ctrl_r)
      | (p2_pin_in & ~port2_direction_ctrl_r)); // [R3] [R4]
    p3_read_val = 8'((port3_data_latch_r & port3_direction_ctrl_r)
      | (p3_pin_in & ~port3_direction_ctrl_r)); // [R11] [R12] [R13]
    aux_read_val = `AUX_RSVD_ONES;
    aux_read_val[`AUX_TXD_BIT] = aux_txd_r;
    aux_read_val[`AUX_POF_BIT] = aux_pof_r;
  end

  // register next values
  always_comb begin
    port2_data_latch_nxt = port2_data_latch_r;
    port2_direction_ctrl_nxt = port2_direction_ctrl_r;
    port3_data_latch_nxt = port3_data_latch_r;
    port3_direction_ctrl_nxt = port3_direction_ctrl_r;
    port3_pullup_ctrl_nxt = port3_pullup_ctrl_r;
    pin_mode_nxt = pin_mode_r;
    aux_txd_nxt = aux_txd_r;
    aux_pof_nxt = aux_pof_r;
    rdata_nxt = `UNMAPPED_READ;
    if (reg_wr) begin
      case (reg_addr)
        // latch takes the write whatever the direction
        `P2_DATA_ADDR: port2_data_latch_nxt = reg_wdata[P2_PINS-1:0]; // [R16]
        `P2_DIR_ADDR: port2_direction_ctrl_nxt = reg_wdata[P2_PINS-1:0];
        // upper bits have no storage, so writes vanish
        `P3_DATA_ADDR: port3_data_latch_nxt = reg_wdata[P3_PINS-1:0]; // [R13]
        `P3_DIR_ADDR: port3_direction_ctrl_nxt = reg_wdata[P3_PINS-1:0];
        `P3_PULLUP_ADDR: port3_pullup_ctrl_nxt = reg_wdata[P3_PINS-1:0];
        `P3_PIN_MODE_ADDR: pin_mode_nxt = reg_wdata[`P3_MODE_BITS-1:0];
        `AUX_PIN_MODE_ADDR: begin
          aux_txd_nxt = reg_wdata[`AUX_TXD_BIT];
          aux_pof_nxt = reg_wdata[`AUX_POF_BIT];
        end
        default: port2_data_latch_nxt = port2_data_latch_r;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        `P2_DATA_ADDR: rdata_nxt = p2_read_val; // [R3] [R4]
        `P2_DIR_ADDR: rdata_nxt = `WO_READ_VALUE; // [R5]
        `P3_DATA_ADDR: rdata_nxt = p3_read_val; // [R12]
        `P3_DIR_ADDR: rdata_nxt = `WO_READ_VALUE;
        `P3_PULLUP_ADDR: rdata_nxt = 8'(port3_pullup_ctrl_r);
        `P3_PIN_MODE_ADDR: rdata_nxt = 8'(pin_mode_r);
        `AUX_PIN_MODE_ADDR: rdata_nxt = aux_read_val;
        default: rdata_nxt = `UNMAPPED_READ;
      endcase
    end
  end

  // serial side data and pull-up enables
  always_comb begin
    // receive line idles high when not routed
    rx_data_nxt = serial_rx_enable ? p2_pin_in[`P2_RXD_BIT] : 1'b1; // [R8]
    clk_in_nxt = clock_select_high ? p2_pin_in[`P2_SCK_BIT] : 1'b0; // [R9]
    // pull-up only on input-direction pins
    pullup_nxt = port3_pullup_ctrl_r & ~port3_direction_ctrl_r;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      port2_data_latch_r <= P2_PINS'(`DATA_RESET); // [R7]
      port2_direction_ctrl_r <= P2_PINS'(`DIR_RESET); // [R7]
      port3_data_latch_r <= P3_PINS'(`DATA_RESET); // [R13]
      port3_direction_ctrl_r <= P3_PINS'(`DIR_RESET);
      port3_pullup_ctrl_r <= P3_PINS'(`DATA_RESET);
      pin_mode_r <= `P3_MODE_BITS'(`DATA_RESET);
      aux_txd_r <= AUX_INIT[`AUX_TXD_BIT]; // [R14]
      aux_pof_r <= AUX_INIT[`AUX_POF_BIT]; // [R14]
      rdata_r <= `UNMAPPED_READ;
      rx_data_r <= 1'b1;
      clk_in_r <= 1'b0;
      pullup_r <= P3_PINS'(`DATA_RESET);
    end else begin
      port2_data_latch_r <= port2_data_latch_nxt;
      port2_direction_ctrl_r <= port2_direction_ctrl_nxt;
      port3_data_latch_r <= port3_data_latch_nxt;
      port3_direction_ctrl_r <= port3_direction_ctrl_nxt;
      port3_pullup_ctrl_r <= port3_pullup_ctrl_nxt;
      pin_mode_r <= pin_mode_nxt;
      aux_txd_r <= aux_txd_nxt;
      aux_pof_r <= aux_pof_nxt;
      rdata_r <= rdata_nxt;
      rx_data_r <= rx_data_nxt;
      clk_in_r <= clk_in_nxt;
      pullup_r <= pullup_nxt;
    end
  end

  // port 2 pin function selection
  always_comb begin
    p2_want_out = port2_data_latch_r; // [R1] [R2]
    p2_want_oe = port2_direction_ctrl_r; // [R2]
    if (aux_txd_r) begin
      p2_want_out[`P2_TXD_BIT] = serial_tx_data; // [R15] [R6]
      p2_want_oe[`P2_TXD_BIT] = 1'b1; // [R15]
    end
    if (serial_rx_enable) begin
      p2_want_oe[`P2_RXD_BIT] = 1'b0; // [R8] [R6]
    end
    if (clock_select_high) begin
      p2_want_oe[`P2_SCK_BIT] = 1'b0; // [R9]
    end else if (clock_select_low || serial_sync_mode) begin
      p2_want_out[`P2_SCK_BIT] = serial_clock_out; // [R9] [R6]
      p2_want_oe[`P2_SCK_BIT] = 1'b1; // [R9]
    end
    want_out = {port3_data_latch_r, p2_want_out}; // [R11]
    want_oe = {port3_direction_ctrl_r, p2_want_oe};
    want_od = '0;
    want_od[P2_PINS + `P3_OD_BIT] = aux_pof_r;
  end

  // one registered driver per pad, port 2 first then port 3
  genvar gi;
  generate
    for (gi = 0; gi < NP; gi++) begin : g_pin
      gpio_pin_drv u_drv (
        .clk(clk),
        .sys_rst(sys_rst),
        .func_en(func_en), // [R10]
        .hiz_en(hiz_en), // [R10]
        .drive_val(want_out[gi]),
        .drive_en(want_oe[gi]),
        .open_drain(want_od[gi]),
        .pin_out(pin_out_all[gi]),
        .pin_oe(pin_oe_all[gi])
      );
    end
  endgenerate

  assign p2_pin_out = pin_out_all[P2_PINS-1:0];
  assign p2_pin_oe = pin_oe_all[P2_PINS-1:0];
  assign p3_pin_out = pin_out_all[NP-1:P2_PINS];
  assign p3_pin_oe = pin_oe_all[NP-1:P2_PINS];
  assign p3_pullup_en = pullup_r;
  assign port3_pin_mode_sel = pin_mode_r;
  assign reg_rdata = rdata_r;
  assign serial_rx_data = rx_data_r;
  assign serial_clock_in = clk_in_r;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  dir_read_ones_a: assert property ( // [R5]
    reg_rd && reg_addr == `P2_DIR_ADDR |=> reg_rdata == 8'hFF)
    else $error("direction read not all ones");

  p2_read_mix_a: assert property ( // [R3]
    reg_rd && reg_addr == `P2_DATA_ADDR
    |=> ((reg_rdata ^ 8'($past(port2_data_latch_r)))
      & 8'($past(port2_direction_ctrl_r))) == 8'h00)
    else $error("port 2 read value wrong");

  p2_input_read_a: assert property ( // [R4]
    reg_rd && reg_addr == `P2_DATA_ADDR && port2_direction_ctrl_r == '0
    |=> reg_rdata == 8'($past(p2_pin_in)))
    else $error("input pins not read live");

  reset_clear_a: assert property ( // [R7]
    $fell(sys_rst) |-> port2_data_latch_r == '0
      && port2_direction_ctrl_r == '0 && p2_pin_oe == '0)
    else $error("port 2 not cleared by reset");

  aux_reset_a: assert property ( // [R14]
    $fell(sys_rst) |-> aux_read_val == 8'hF8)
    else $error("aux mode reset value wrong");

  rx_pin_in_a: assert property ( // [R8]
    serial_rx_enable && func_en |=> !p2_pin_oe[`P2_RXD_BIT])
    else $error("receive pin driven");

  sck_in_a: assert property ( // [R9]
    clock_select_high && func_en |=> !p2_pin_oe[`P2_SCK_BIT])
    else $error("clock input pin driven");

  sck_out_a: assert property ( // [R9]
    !clock_select_high && (clock_select_low || serial_sync_mode) && func_en
    |=> p2_pin_oe[`P2_SCK_BIT]
      && p2_pin_out[`P2_SCK_BIT] == $past(serial_clock_out))
    else $error("clock output pin wrong");

  txd_out_a: assert property ( // [R15]
    aux_txd_r && func_en |=> p2_pin_oe[`P2_TXD_BIT]
      && p2_pin_out[`P2_TXD_BIT] == $past(serial_tx_data))
    else $error("transmit pin wrong");

  gpio_drive_a: assert property ( // [R2]
    func_en && port2_direction_ctrl_r[P2_PINS-1]
    |=> p2_pin_oe[P2_PINS-1]
      && p2_pin_out[P2_PINS-1] == $past(port2_data_latch_r[P2_PINS-1]))
    else $error("output pin not driven from latch");

  standby_hiz_a: assert property ( // [R10]
    hiz_en |=> p2_pin_oe == '0 ##1 (hiz_en ? p2_pin_oe == '0 : 1'b1))
    else $error("pins driven in standby");

  sleep_hold_a: assert property ( // [R10]
    !func_en && !hiz_en |=> $stable(p2_pin_out) && $stable(p2_pin_oe))
    else $error("pins changed while held");

  p3_upper_zero_a: assert property ( // [R13]
    reg_rd && reg_addr == `P3_DATA_ADDR |=> reg_rdata[7:6] == 2'h0)
    else $error("port 3 upper bits not zero");

  latch_write_a: assert property ( // [R16]
    reg_wr && reg_addr == `P2_DATA_ADDR
    |=> port2_data_latch_r == $past(reg_wdata))
    else $error("data write lost");
endmodule

// ---- verif/port2_port3_gpio_tb.sv ----
// self-checking bench for the port 2/3 gpio block
// assumes the design files and gpio_defs.svh are compiled first
`timescale 1ns/1ps
module port2_port3_gpio_tb;
  import gpio_pkg::*;
  // clock and reset
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  // register port
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  // mode and serial unit
  power_mode_t power_mode = PM_ACTIVE;
  logic serial_rx_enable = 1'b0;
  logic clock_select_high = 1'b0;
  logic clock_select_low = 1'b0;
  logic serial_sync_mode = 1'b0;
  logic serial_tx_data = 1'b0;
  logic serial_clock_out = 1'b0;
  logic serial_rx_data;
  logic serial_clock_in;
  // pads
  logic [7:0] p2_pin_in = 8'h00;
  logic [7:0] p2_pin_out;
  logic [7:0] p2_pin_oe;
  logic [5:0] p3_pin_in = 6'h00;
  logic [5:0] p3_pin_out;
  logic [5:0] p3_pin_oe;
  logic [5:0] p3_pullup_en;
  logic [2:0] port3_pin_mode_sel;
  int err_total = 0;
  int samples_checked = 0;
  logic [7:0] rd;

  always #12.5 clk = ~clk;

  port2_port3_gpio #(.P2_PINS(8), .P3_PINS(6)) DUT (
    .clk(clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .power_mode(power_mode),
    .serial_rx_enable(serial_rx_enable),
    .clock_select_high(clock_select_high),
    .clock_select_low(clock_select_low),
    .serial_sync_mode(serial_sync_mode), .serial_tx_data(serial_tx_data),
    .serial_clock_out(serial_clock_out), .serial_rx_data(serial_rx_data),
    .serial_clock_in(serial_clock_in), .p2_pin_in(p2_pin_in),
    .p2_pin_out(p2_pin_out), .p2_pin_oe(p2_pin_oe), .p3_pin_in(p3_pin_in),
    .p3_pin_out(p3_pin_out), .p3_pin_oe(p3_pin_oe),
    .p3_pullup_en(p3_pullup_en), .port3_pin_mode_sel(port3_pin_mode_sel)
  );

  task automatic end_of_test();
    if (err_total == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string n, input logic [7:0] e,
                     input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", n, e, g);
      err_total++;
    end
  endtask

  // strobe dropped one edge later, so calls never collide in a time step
  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // data stands only in the cycle after the read edge
  task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic test_reset_values();
    chk("p2 oe after reset", 8'h00, p2_pin_oe);
    rd_reg(16'hFFD5, rd);
    chk("p2 data reset", 8'h00, rd);
    rd_reg(16'hFFE5, rd);
    chk("p2 dir read", 8'hFF, rd);
    rd_reg(16'hFFD6, rd);
    chk("p3 data reset", 8'h00, rd);
    rd_reg(16'hFFFF, rd);
    chk("aux reset", 8'hF8, rd);
    rd_reg(16'hFFF0, rd);
    chk("unmapped read", 8'h00, rd);
  endtask

  task automatic test_p2_gpio();
    p2_pin_in <= 8'h3C;
    wr_reg(16'hFFD5, 8'hA5);
    wait_cyc(3);
    chk("p2 oe all input", 8'h00, p2_pin_oe);
    rd_reg(16'hFFD5, rd);
    chk("p2 read inputs", 8'h3C, rd);
    wr_reg(16'hFFE5, 8'h0F);
    wait_cyc(3);
    chk("p2 oe low nibble", 8'h0F, p2_pin_oe);
    chk("p2 out low nibble", 8'h05, {4'h0, p2_pin_out[3:0]});
    rd_reg(16'hFFD5, rd);
    chk("p2 mixed read", 8'h35, rd);
    rd_reg(16'hFFE5, rd);
    chk("p2 dir read set", 8'hFF, rd);
  endtask

  task automatic test_p3_gpio();
    p3_pin_in <= 6'h2A;
    wr_reg(16'hFFD6, 8'hFF);
    wr_reg(16'hFFE6, 8'h07);
    wait_cyc(3);
    chk("p3 oe", 8'h07, {2'h0, p3_pin_oe});
    chk("p3 out", 8'h07, {5'h00, p3_pin_out[2:0]});
    rd_reg(16'hFFD6, rd);
    chk("p3 mixed read", 8'h2F, rd);
  endtask

  task automatic test_serial();
    wr_reg(16'hFFE5, 8'hFF);
    wr_reg(16'hFFD5, 8'h00);
    p2_pin_in <= 8'h01;
    serial_rx_enable <= 1'b1;
    clock_select_high <= 1'b1;
    serial_tx_data <= 1'b1;
    wr_reg(16'hFFFF, 8'h04);
    wait_cyc(3);
    chk("p2 oe serial", 8'hFC, p2_pin_oe);
    chk("tx on pin 2", 8'h01, {7'h00, p2_pin_out[2]});
    chk("rx data", 8'h00, {7'h00, serial_rx_data});
    chk("clock in", 8'h01, {7'h00, serial_clock_in});
    rd_reg(16'hFFFF, rd);
    chk("aux read", 8'hFC, rd);
    clock_select_high <= 1'b0;
    clock_select_low <= 1'b1;
    serial_clock_out <= 1'b1;
    wait_cyc(3);
    chk("clock out low oe", 8'h01, {7'h00, p2_pin_oe[0]});
    chk("clock out low val", 8'h01, {7'h00, p2_pin_out[0]});
    chk("clock in idle", 8'h00, {7'h00, serial_clock_in});
    clock_select_low <= 1'b0;
    serial_sync_mode <= 1'b1;
    wait_cyc(3);
    chk("clock out sync oe", 8'h01, {7'h00, p2_pin_oe[0]});
    chk("clock out sync val", 8'h01, {7'h00, p2_pin_out[0]});
    serial_sync_mode <= 1'b0;
    serial_rx_enable <= 1'b0;
    wr_reg(16'hFFFF, 8'h00);
    wait_cyc(3);
    chk("p2 oe gpio again", 8'hFF, p2_pin_oe);
    chk("p2 out gpio again", 8'h00, p2_pin_out);
    chk("rx idle", 8'h01, {7'h00, serial_rx_data});
  endtask

  // pull-ups, pin mode export, open drain on port 3 pin 2, idle read data
  task automatic test_p3_extras();
    wr_reg(16'hFFEE, 8'hFF);
    wr_reg(16'hFFFD, 8'hFF);
    wr_reg(16'hFFFF, 8'h01);
    wait_cyc(3);
    chk("p3 pullup en", 8'h38, {2'h0, p3_pullup_en});
    chk("p3 mode sel", 8'h07, {5'h00, port3_pin_mode_sel});
    chk("p3 oe open drain", 8'h03, {2'h0, p3_pin_oe});
    rd_reg(16'hFFEE, rd);
    chk("pullup read", 8'h3F, rd);
    rd_reg(16'hFFFD, rd);
    chk("pin mode read", 8'h07, rd);
    rd_reg(16'hFFE6, rd);
    chk("p3 dir read", 8'hFF, rd);
    rd_reg(16'hFFFF, rd);
    chk("aux read od", 8'hF9, rd);
    wait_cyc(1);
    chk("rdata idle", 8'h00, reg_rdata);
    wr_reg(16'hFFFF, 8'h00);
  endtask

  task automatic test_pin_states();
    power_mode_t hold_modes [3] = '{PM_SLEEP, PM_SUBSLEEP, PM_WATCH};
    foreach (hold_modes[i]) begin
      power_mode <= hold_modes[i];
      wait_cyc(1);
      wr_reg(16'hFFD5, 8'hFF);
      wait_cyc(3);
      chk("held oe", 8'hFF, p2_pin_oe);
      chk("held out", 8'h00, p2_pin_out);
      wr_reg(16'hFFD5, 8'h00);
    end
    power_mode <= PM_STANDBY;
    wait_cyc(3);
    chk("standby oe", 8'h00, p2_pin_oe);
    power_mode <= PM_SUBACTIVE;
    wr_reg(16'hFFD5, 8'h5A);
    wait_cyc(3);
    chk("subactive out", 8'h5A, p2_pin_out);
    sys_rst <= 1'b1;
    wait_cyc(2);
    chk("oe in reset", 8'h00, p2_pin_oe);
    sys_rst <= 1'b0;
    p2_pin_in <= 8'h00;
    wait_cyc(3);
    chk("oe after reset", 8'h00, p2_pin_oe);
    rd_reg(16'hFFD5, rd);
    chk("data after reset", 8'h00, rd);
  endtask

  initial begin
    repeat (19) @(posedge clk);
    #1 chk("oe during reset", 8'h00, p2_pin_oe);
    @(posedge clk);
    sys_rst <= 1'b0;
    wait_cyc(2);
    test_reset_values();
    test_p2_gpio();
    test_p3_gpio();
    test_serial();
    test_p3_extras();
    test_pin_states();
    end_of_test();
  end

  initial begin
    #(25 * 3000);
    err_total++;
    end_of_test();
  end
endmodule
